/* psd_pkg.sv */
// Shared constants, states and carriers of the LED dimming control block
package psd_pkg;
  localparam int NCH = 6;
  localparam int CLK_MHZ = 100;
  localparam int DETECT_TIME_US = 4000;
  localparam int DETECT_CYCLES = DETECT_TIME_US * CLK_MHZ;
  localparam int DIM_FREQ_HZ = 20000;
  localparam int DIM_PERIOD_CYCLES = CLK_MHZ * 1000000 / DIM_FREQ_HZ;
  localparam int PER_W = 20;
  localparam int DUTY_W = 8;
  localparam int DUTY_SHIFT = 8;
  localparam logic [DUTY_W-1:0] DUTY_HYST = 8'h02;
  localparam logic [DUTY_W-1:0] DUTY_MAX = 8'hff;
  localparam int OC_SUSTAIN = 8;
  localparam logic [PER_W-1:0] MIN_PERIOD = 20'h0_0040;
  localparam int AW = 8;
  ////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [AW-1:0] ADDR_PERIOD = 8'h00;
  localparam logic [AW-1:0] ADDR_STATUS = 8'h04;
  localparam logic [AW-1:0] ADDR_CHAN = 8'h08;
  localparam logic [AW-1:0] ADDR_DUTY = 8'h0c;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_OC_BIT = 4;
  localparam int STAT_SHORT_BIT = 5;
  localparam int STAT_TEMP_BIT = 6;
  localparam int STAT_ALLOPEN_BIT = 7;
  localparam int STAT_DIRECT_BIT = 8;
  localparam int STAT_BOOST_BIT = 9;
  localparam int STAT_SEEN_BIT = 10;
  localparam int CHAN_OPEN_LSB = 8;
  localparam int CHAN_OV_LSB = 16;
  localparam int CHAN_SINK_LSB = 24;
  ////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {ST_OFF, ST_DETECT, ST_RUN, ST_SHUT} psd_state_t;
  typedef struct packed {
    logic [AW-1:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [AW-1:0] araddr;
    logic arvalid;
    logic rready;
  } psd_axi_req_t;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } psd_axi_rsp_t;
  typedef struct packed {
    logic ovc_high;
    logic sw_overcurrent;
    logic out_short;
    logic over_temp;
    logic sw_cycle_start;
  } psd_flt_t;
  typedef struct packed {
    logic [NCH-1:0] below_600mv;
    logic [NCH-1:0] no_current;
    logic [NCH-1:0] over_volt;
  } psd_chan_in_t;
endpackage

/* psd_duty_decoder.sv */
// Duty-cycle decoder of the dimming input with one LSB of hysteresis
`timescale 1ns/100ps
module psd_duty_decoder #(
  parameter int CW = psd_pkg::PER_W
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control and input
  input wire logic enable,
  input wire logic dim_in,
  // Result
  output logic [psd_pkg::DUTY_W-1:0] duty,
  output logic seen
);
  if (CW < psd_pkg::DUTY_W) begin : g_chk
    $error("psd_duty_decoder: counter width too small");
  end

  typedef struct packed {
    logic dim_q;
    logic started;
    logic seen;
    logic [CW-1:0] high_cnt;
    logic [CW-1:0] per_cnt;
    logic [psd_pkg::DUTY_W-1:0] held;
  } psd_dec_t;

  psd_dec_t s, next_s;
  logic [CW+7:0] raw_full;
  logic [psd_pkg::DUTY_W-1:0] raw;
  logic rise;

  // Ratio of high time to period, scaled to 0..255
  always_comb begin
    rise = dim_in && !s.dim_q;
    raw_full = {s.high_cnt, 8'h00} / {8'h00, s.per_cnt};
    raw = (raw_full > {{CW{1'b0}}, psd_pkg::DUTY_MAX}) ? psd_pkg::DUTY_MAX
        : raw_full[psd_pkg::DUTY_W-1:0];
  end

  // Counting, storing and hysteresis
  always_comb begin
    next_s = s;
    next_s.dim_q = dim_in;
    if (!enable) begin
      next_s = '0;
    end else begin
      if (dim_in != s.dim_q) begin
        next_s.seen = 1'b1;
      end
      if (&s.per_cnt == 1'b0) begin
        next_s.per_cnt = s.per_cnt + 1'b1;
      end
      if (dim_in && (&s.high_cnt == 1'b0)) begin
        next_s.high_cnt = s.high_cnt + 1'b1;
      end
      if (rise) begin
        next_s.started = 1'b1;
        next_s.per_cnt = {{(CW-1){1'b0}}, 1'b1};
        next_s.high_cnt = {{(CW-1){1'b0}}, 1'b1};
        if (s.started && s.per_cnt != '0) begin
          if (raw > s.held) begin
            next_s.held = raw;
          end else if (s.held - raw >= psd_pkg::DUTY_HYST) begin
            next_s.held = raw;
          end
        end
      end
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign duty = s.held;
  assign seen = s.seen;

  a_dec_disabled: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !enable |=> (duty == '0 && !seen))
    else $error("decoder active while disabled");
  a_dec_hyst: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (enable && rise && s.started && raw < s.held
     && s.held - raw < psd_pkg::DUTY_HYST)
    |=> $stable(duty))
    else $error("duty moved inside hysteresis band");
endmodule

/* psd_phase_slot.sv */
// One channel's on-window within the shared dimming period
`timescale 1ns/100ps
module psd_phase_slot #(
  parameter int PW = psd_pkg::PER_W
) (
  // Shared period timing
  input wire logic [PW-1:0] cnt,
  input wire logic [PW-1:0] period,
  // Channel slot
  input wire logic [PW-1:0] offset,
  input wire logic [PW-1:0] on_cycles,
  output logic on
);
  if (PW < 2) begin : g_chk
    $error("psd_phase_slot: width too small");
  end

  logic [PW-1:0] phase;

  // Position in the period relative to this channel's start
  always_comb begin
    if (cnt >= offset) begin
      phase = cnt - offset;
    end else begin
      phase = cnt + period - offset;
    end
    on = phase < on_cycles;
  end
endmodule

/* psd_top.sv */
// Six-channel LED dimming control: detection, dimming and fault latching
`timescale 1ns/100ps
module psd_top #(
  parameter int DETECT_CYCLES = psd_pkg::DETECT_CYCLES,
  parameter int DIM_PERIOD = psd_pkg::DIM_PERIOD_CYCLES,
  parameter int OC_SUSTAIN = psd_pkg::OC_SUSTAIN
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire psd_pkg::psd_axi_req_t s_axi_req,
  output psd_pkg::psd_axi_rsp_t s_axi_rsp,
  // Device pins and comparators
  input wire logic en,
  input wire logic dim_freq_mode_select,
  input wire logic dimming_duty_input,
  input wire psd_pkg::psd_chan_in_t chan_in,
  input wire psd_pkg::psd_flt_t flt_in,
  // Sink and boost control
  output logic [psd_pkg::NCH-1:0] sink_on,
  output logic [psd_pkg::NCH-1:0] fb_select,
  output logic probe_en,
  output logic boost_en,
  output logic shutdown
);
  localparam int NCH = psd_pkg::NCH;
  localparam int PW = psd_pkg::PER_W;
  localparam int TW = $clog2(DETECT_CYCLES + 1);
  localparam int OCW = $clog2(OC_SUSTAIN + 1);

  if (DETECT_CYCLES < 1 || OC_SUSTAIN < 1 || DIM_PERIOD < psd_pkg::MIN_PERIOD
      || DIM_PERIOD >= (1 << PW)) begin : g_chk
    $error("psd_top: parameter out of range");
  end

  typedef struct packed {
    psd_pkg::psd_state_t fsm;
    logic [TW-1:0] timer;
    logic [NCH-1:0] unused;
    logic [NCH-1:0] open_lat;
    logic [NCH-1:0] ov_lat;
    logic [NCH-1:0] sink_on;
    logic [NCH-1:0] fb_sel;
    logic probe_en;
    logic boost_en;
    logic shut;
    logic oc_block;
    logic [OCW-1:0] oc_cnt;
    logic flt_oc;
    logic flt_short;
    logic flt_temp;
    logic flt_allopen;
    logic dir_seen;
    logic [PW-1:0] period;
    logic [PW-1:0] dim_cnt;
    logic aw_full;
    logic w_full;
    logic [psd_pkg::AW-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    psd_pkg::psd_axi_rsp_t rsp;
  } psd_top_st_t;

  psd_top_st_t s, next_s;

  ////////////////////////////////////////////////////////////////////////
  // Duty decoder and slot timing

  logic dec_enable;
  logic [psd_pkg::DUTY_W-1:0] duty;
  logic dec_seen;
  logic seen;
  logic direct;
  logic [NCH-1:0] active;
  logic [NCH-1:0] slot_on;
  logic [2:0] n_used;
  logic [2:0] rank [NCH];
  logic [PW-1:0] slot_delay;
  logic [PW-1:0] on_cycles;
  logic [PW+7:0] on_prod;
  logic [PW+2:0] off_prod [NCH];
  logic [PW-1:0] offset [NCH];

  // Mode pin high selects direct mode
  assign direct = dim_freq_mode_select;
  assign dec_enable = (s.fsm == psd_pkg::ST_RUN) && !direct;
  assign seen = direct ? s.dir_seen : dec_seen;
  assign active = ~s.unused & ~s.open_lat & ~s.ov_lat;

  psd_duty_decoder #(
    .CW(PW)
  ) u_dec (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(dec_enable),
    .dim_in(dimming_duty_input),
    .duty(duty),
    .seen(dec_seen)
  );

  // Slot spacing: period over used channels, ranked in channel order
  always_comb begin
    n_used = '0;
    for (int i = 0; i < NCH; i++) begin
      rank[i] = n_used;
      n_used = n_used + {2'h0, ~s.unused[i]};
    end
    slot_delay = s.period / PW'((n_used == '0) ? 3'h1 : n_used);
    on_prod = s.period * duty;
    on_cycles = on_prod[PW+7:psd_pkg::DUTY_SHIFT];
    for (int i = 0; i < NCH; i++) begin
      off_prod[i] = slot_delay * rank[i];
      offset[i] = off_prod[i][PW-1:0];
    end
  end

  for (genvar g = 0; g < NCH; g++) begin : g_slot
    psd_phase_slot #(
      .PW(PW)
    ) u_slot (
      .cnt(s.dim_cnt),
      .period(s.period),
      .offset(offset[g]),
      .on_cycles(on_cycles),
      .on(slot_on[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // Register read mux

  function automatic logic [31:0] rd_word(input psd_top_st_t st,
                                          input logic [psd_pkg::AW-1:0] a,
                                          input logic [7:0] d,
                                          input logic sn,
                                          input logic dm);
    logic [31:0] v;
    v = '0;
    unique case (a)
      psd_pkg::ADDR_PERIOD: v[PW-1:0] = st.period;
      psd_pkg::ADDR_STATUS: begin
        v[psd_pkg::STAT_STATE_LSB +: 2] = st.fsm;
        v[psd_pkg::STAT_OC_BIT] = st.flt_oc;
        v[psd_pkg::STAT_SHORT_BIT] = st.flt_short;
        v[psd_pkg::STAT_TEMP_BIT] = st.flt_temp;
        v[psd_pkg::STAT_ALLOPEN_BIT] = st.flt_allopen;
        v[psd_pkg::STAT_DIRECT_BIT] = dm;
        v[psd_pkg::STAT_BOOST_BIT] = st.boost_en;
        v[psd_pkg::STAT_SEEN_BIT] = sn;
      end
      psd_pkg::ADDR_CHAN: begin
        v[NCH-1:0] = st.unused;
        v[psd_pkg::CHAN_OPEN_LSB +: NCH] = st.open_lat;
        v[psd_pkg::CHAN_OV_LSB +: NCH] = st.ov_lat;
        v[psd_pkg::CHAN_SINK_LSB +: NCH] = st.sink_on;
      end
      psd_pkg::ADDR_DUTY: v[7:0] = d;
      default: v = '0;
    endcase
    return v;
  endfunction

  function automatic logic mapped(input logic [psd_pkg::AW-1:0] a);
    return a == psd_pkg::ADDR_PERIOD || a == psd_pkg::ADDR_STATUS
        || a == psd_pkg::ADDR_CHAN || a == psd_pkg::ADDR_DUTY;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Next state: bus slave, sequencing, dimming and faults

  logic [31:0] merged;
  logic [NCH-1:0] next_open;
  logic [NCH-1:0] dim_on;

  always_comb begin
    next_s = s;
    merged = {{(32-PW){1'b0}}, s.period};
    next_open = s.open_lat;
    dim_on = '0;
    // Write address and data taken in either order
    if (s_axi_req.awvalid && s.rsp.awready) begin
      next_s.aw_full = 1'b1;
      next_s.awaddr = s_axi_req.awaddr;
    end
    if (s_axi_req.wvalid && s.rsp.wready) begin
      next_s.w_full = 1'b1;
      next_s.wdata = s_axi_req.wdata;
      next_s.wstrb = s_axi_req.wstrb;
    end
    if (s.rsp.bvalid && s_axi_req.bready) begin
      next_s.rsp.bvalid = 1'b0;
    end
    // Both halves held: perform write and raise response
    if (s.aw_full && s.w_full && !s.rsp.bvalid) begin
      next_s.aw_full = 1'b0;
      next_s.w_full = 1'b0;
      next_s.rsp.bvalid = 1'b1;
      next_s.rsp.bresp = mapped(s.awaddr) ? psd_pkg::RESP_OKAY
                                         : psd_pkg::RESP_DECERR;
      for (int b = 0; b < 4; b++) begin
        if (s.wstrb[b]) begin
          merged[8*b +: 8] = s.wdata[8*b +: 8];
        end
      end
      // Too short a period is ignored
      if (s.awaddr == psd_pkg::ADDR_PERIOD && merged[31:PW] == '0
          && merged[PW-1:0] >= psd_pkg::MIN_PERIOD) begin
        next_s.period = merged[PW-1:0];
      end
    end
    next_s.rsp.awready = !next_s.aw_full;
    next_s.rsp.wready = !next_s.w_full;
    // Read channel
    if (s.rsp.rvalid && s_axi_req.rready) begin
      next_s.rsp.rvalid = 1'b0;
    end
    if (s_axi_req.arvalid && s.rsp.arready) begin
      next_s.rsp.rvalid = 1'b1;
      next_s.rsp.rdata = rd_word(s, s_axi_req.araddr, duty, seen, direct);
      next_s.rsp.rresp = mapped(s_axi_req.araddr) ? psd_pkg::RESP_OKAY
                                                  : psd_pkg::RESP_DECERR;
    end
    next_s.rsp.arready = !next_s.rsp.rvalid;

    // Dimming period counter, wraps at the programmed period
    if (s.dim_cnt >= s.period - 1'b1) begin
      next_s.dim_cnt = '0;
    end else begin
      next_s.dim_cnt = s.dim_cnt + 1'b1;
    end

    // Device sequencing
    next_s.probe_en = 1'b0;
    next_s.sink_on = '0;
    next_s.fb_sel = '0;
    next_s.boost_en = 1'b0;
    unique case (s.fsm)
      psd_pkg::ST_OFF: begin
        if (en) begin
          next_s.fsm = psd_pkg::ST_DETECT;
          next_s.timer = '0;
          next_s.probe_en = 1'b1;
        end
      end
      psd_pkg::ST_DETECT: begin
        next_s.probe_en = 1'b1;
        next_s.timer = s.timer + 1'b1;
        if (s.timer == TW'(DETECT_CYCLES - 1)) begin
          next_s.probe_en = 1'b0;
          next_s.unused = chan_in.below_600mv;
          next_s.fsm = psd_pkg::ST_RUN;
          next_s.dim_cnt = '0;
        end
      end
      psd_pkg::ST_RUN: begin
        if (dimming_duty_input) begin
          next_s.dir_seen = 1'b1;
        end
        // Latch open and overvoltage channels
        next_open = s.open_lat | (chan_in.no_current & s.sink_on & active);
        next_s.open_lat = next_open;
        next_s.ov_lat = s.ov_lat | (chan_in.over_volt & ~s.unused);
        // Pulse-by-pulse limit, set wins over cycle restart
        if (flt_in.sw_overcurrent) begin
          next_s.oc_block = 1'b1;
        end else if (flt_in.sw_cycle_start) begin
          next_s.oc_block = 1'b0;
        end
        if (flt_in.sw_cycle_start) begin
          next_s.oc_cnt = s.oc_block ? s.oc_cnt + 1'b1 : '0;
        end
        if (s.oc_block && flt_in.sw_cycle_start
            && s.oc_cnt == OCW'(OC_SUSTAIN - 1)) begin
          next_s.flt_oc = 1'b1;
        end
        next_s.flt_short = flt_in.out_short;
        next_s.flt_temp = flt_in.over_temp;
        next_s.flt_allopen = ((~s.unused & ~next_open) == '0);
        if (next_s.flt_oc || next_s.flt_short || next_s.flt_temp
            || next_s.flt_allopen) begin
          next_s.fsm = psd_pkg::ST_SHUT;
        end else begin
          // Sinks stay dark until a dimming signal appears
          if (direct) begin
            dim_on = {NCH{dimming_duty_input}};
          end else begin
            dim_on = slot_on;
          end
          next_s.sink_on = seen ? (dim_on & active) : '0;
          next_s.fb_sel = active;
          next_s.boost_en = seen && !flt_in.ovc_high
              && !next_s.oc_block;
        end
      end
      psd_pkg::ST_SHUT: begin
        next_s.fsm = psd_pkg::ST_SHUT;
      end
    endcase
    // Enable low: stop everything and clear all latches
    if (!en) begin
      next_s.fsm = psd_pkg::ST_OFF;
      next_s.probe_en = 1'b0;
      next_s.sink_on = '0;
      next_s.fb_sel = '0;
      next_s.boost_en = 1'b0;
      next_s.unused = '0;
      next_s.open_lat = '0;
      next_s.ov_lat = '0;
      next_s.oc_block = 1'b0;
      next_s.oc_cnt = '0;
      next_s.flt_oc = 1'b0;
      next_s.flt_short = 1'b0;
      next_s.flt_temp = 1'b0;
      next_s.flt_allopen = 1'b0;
      next_s.dir_seen = 1'b0;
    end
    next_s.shut = (next_s.fsm == psd_pkg::ST_SHUT);
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.period <= PW'(DIM_PERIOD);
      s.rsp.awready <= 1'b1;
      s.rsp.wready <= 1'b1;
      s.rsp.arready <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign s_axi_rsp = s.rsp;
  assign sink_on = s.sink_on;
  assign fb_select = s.fb_sel;
  assign probe_en = s.probe_en;
  assign boost_en = s.boost_en;
  assign shutdown = s.shut;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_detect_sample: assert property (
    (en && s.fsm == psd_pkg::ST_DETECT && s.timer == TW'(DETECT_CYCLES - 1))
    |=> (s.unused == $past(chan_in.below_600mv) && !s.probe_en))
    else $error("unused mask not taken at end of detection");
  a_unused_dark: assert property (
    ((s.sink_on | s.fb_sel) & s.unused) == '0)
    else $error("unused channel driven");
  a_direct_follow: assert property (
    (en && s.fsm == psd_pkg::ST_RUN && direct && seen
     && !flt_in.out_short && !flt_in.over_temp && !next_s.flt_oc
     && !next_s.flt_allopen)
    |=> s.sink_on == ({NCH{$past(dimming_duty_input)}} & $past(active)))
    else $error("direct mode sinks do not follow input");
  a_clamp_inhibit: assert property (
    (s.fsm == psd_pkg::ST_RUN && flt_in.ovc_high) |=> !s.boost_en)
    else $error("boost running above clamp");
  a_open_sticky: assert property (
    (en && $past(en)) |-> (($past(s.open_lat) & ~s.open_lat) == '0))
    else $error("open latch released without enable toggle");
  a_oc_block: assert property (
    (s.fsm == psd_pkg::ST_RUN && flt_in.sw_overcurrent)
    |=> !s.boost_en ##1 (!s.boost_en || $past(flt_in.sw_cycle_start)))
    else $error("boost restarted inside limited cycle");
  a_shut_hold: assert property (
    (s.fsm == psd_pkg::ST_SHUT && en) |=> (s.shut && s.sink_on == '0))
    else $error("shutdown left without enable toggle");
  a_short_trip: assert property (
    (en && s.fsm == psd_pkg::ST_RUN && (flt_in.out_short || flt_in.over_temp))
    |=> (s.fsm == psd_pkg::ST_SHUT && !s.boost_en && s.sink_on == '0))
    else $error("short or heat did not shut down at once");
  a_enable_low: assert property (
    !en |=> (s.fsm == psd_pkg::ST_OFF && s.sink_on == '0 && !s.boost_en
             && s.open_lat == '0 && !s.flt_oc))
    else $error("enable low did not stop and clear");
  a_no_signal: assert property (
    (s.fsm == psd_pkg::ST_RUN && !seen) |=> (s.sink_on == '0 && !s.boost_en))
    else $error("sinks lit without dimming signal");

  c_run_to_shut: cover property (s.fsm == psd_pkg::ST_RUN ##1 s.shut);
  c_direct_run: cover property (direct && s.sink_on != '0);
  c_all_on: cover property (s.sink_on == {NCH{1'b1}});
  c_unused_seen: cover property (s.fsm == psd_pkg::ST_RUN && s.unused != '0);
endmodule

/* psd_dim_host.sv */
// Host model that drives the dimming input
`timescale 1ns/100ps
module psd_dim_host (
  // Clock and waveform setting
  input wire logic aclk,
  input wire logic [9:0] per,
  input wire logic [9:0] hi,
  // Dimming input drive
  output logic dim = 1'b0
);
  logic [9:0] cnt = 10'h000;
  // Period counter, input high for the first hi cycles
  always_ff @(posedge aclk) begin
    cnt <= (cnt + 10'h001 >= per) ? 10'h000 : cnt + 10'h001;
    dim <= cnt < hi;
  end
endmodule

/* tb_phase_shift_led_dimming_control.sv */
// Self-checking bench of the LED dimming control block
`timescale 1ns/100ps
`define CHK(s, e, g) begin checks_done++; if ((g) !== (e)) begin \
  errors++; $display("mismatch %s exp %h got %h", s, e, g); end end
module tb_phase_shift_led_dimming_control;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic en = 1'b0;
  logic mode = 1'b0;
  logic dim;
  logic d1 = 1'b0;
  logic probe_en, boost_en, shutdown;
  logic [5:0] sink_on, fb;
  logic [7:0] so;
  logic [9:0] per = 10'h000;
  logic [9:0] hi = 10'h000;
  logic [7:0] h;
  logic [65:0] nt;
  logic [65:0] notes[$];
  logic [4:0] fl[4] = '{5'h04, 5'h02, 5'h00, 5'h09};
  int errors = 0;
  int checks_done = 0;
  int k, c, i, o;
  psd_pkg::psd_axi_req_t req = '0;
  psd_pkg::psd_axi_rsp_t rsp;
  psd_pkg::psd_chan_in_t chan = '0;
  psd_pkg::psd_flt_t flt = '0;
  psd_top #(.DETECT_CYCLES(20), .DIM_PERIOD(64), .OC_SUSTAIN(2)) uut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_req(req), .s_axi_rsp(rsp),
    .en(en), .dim_freq_mode_select(mode), .dimming_duty_input(dim),
    .chan_in(chan), .flt_in(flt), .sink_on(sink_on), .fb_select(fb),
    .probe_en(probe_en), .boost_en(boost_en), .shutdown(shutdown));
  psd_dim_host host (.aclk(aclk), .per(per), .hi(hi), .dim(dim));
  // Shutdown, boost and sinks seen together
  assign so = {shutdown, boost_en, sink_on};
  ////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    forever #5 aclk = ~aclk;
  end
  // Match each read answer to the oldest note
  always @(posedge aclk) begin
    if (rsp.rvalid && req.rready) begin
      nt = (notes.size() > 0) ? notes.pop_front() : '1;
      `CHK("read", nt[33:0], {rsp.rresp, rsp.rdata & nt[65:34]})
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Bus tasks
  task automatic lim(input int n);
    if (n >= 50) begin
      errors++;
      test_done();
    end
  endtask
  task automatic wt(input logic [7:0] a, input logic [31:0] d);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    for (k = 0; k < 50 && !rsp.bvalid; k++) begin
      @(posedge aclk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end
    `CHK("bresp", psd_pkg::RESP_OKAY, rsp.bresp)
    req.bready <= 1'b0;
    lim(k);
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m,
                    input logic [33:0] e);
    notes.push_back({m, e});
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    for (k = 0; k < 50 && !rsp.rvalid; k++) begin
      @(posedge aclk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end
    req.rready <= 1'b0;
    lim(k);
    @(posedge aclk);
  endtask
  // Set input duty, let the decoder settle, read held duty
  task automatic step(input logic [7:0] v, input logic [7:0] e);
    hi <= {2'b00, v};
    repeat (700) @(posedge aclk);
    rd(psd_pkg::ADDR_DUTY, 32'h0000_00ff, {26'h0, e});
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    k = $urandom(32'h9fae_19b1);
    h = 8'd80 + 8'($urandom % 100);
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(psd_pkg::ADDR_PERIOD, 32'h000f_ffff, 34'h0_0000_0040);
    rd(8'h10, 32'hffff_ffff, {psd_pkg::RESP_DECERR, 32'h0000_0000});
    wt(psd_pkg::ADDR_PERIOD, 32'h0000_0100);
    wt(psd_pkg::ADDR_PERIOD, 32'h0000_003f);
    rd(psd_pkg::ADDR_PERIOD, 32'h000f_ffff, 34'h0_0000_0100);
    chan.below_600mv <= 6'b10_0001;
    en <= 1'b1;
    for (k = 0; k < 50 && !probe_en; k++) @(posedge aclk);
    lim(k);
    for (c = 1; c < 50 && probe_en; c++) @(posedge aclk);
    `CHK("probe", 20, c - 1)
    repeat (2) @(posedge aclk);
    rd(psd_pkg::ADDR_CHAN, 32'h0000_003f, 34'h0_0000_0021);
    `CHK("idle", 7'h00, {boost_en, sink_on})
    `CHK("feedback", 6'h1e, fb)
    // Direct mode: sinks copy the input one cycle later
    mode <= 1'b1;
    per <= 10'd7;
    hi <= 10'd3;
    for (k = 0; k < 40; k++) begin
      @(posedge aclk);
      if (k > 12) `CHK("direct", {6{d1}} & 6'b01_1110, sink_on)
      d1 = dim;
    end
    rd(psd_pkg::ADDR_STATUS, 32'h0000_0103, 34'h0_0000_0102);
    rd(psd_pkg::ADDR_DUTY, 32'h0000_00ff, 34'h0_0000_0000);
    // Phase mode: decode, hysteresis, on time and channel spacing
    mode <= 1'b0;
    per <= 10'h100;
    step(h, h);
    step(h - 8'd1, h);
    step(h - 8'd2, h - 8'd2);
    step(h - 8'd1, h - 8'd1);
    c = 0;
    o = 0;
    for (k = 0; k < 256; k++) begin
      @(posedge aclk);
      c += sink_on[1];
      o += sink_on[1] & sink_on[2];
    end
    `CHK("on time", int'(h) - 1, c)
    `CHK("overlap", int'(h) - 65, o)
    // Boost runs with a signal, stops while the clamp trips
    `CHK("boost", 1'b1, boost_en)
    flt <= 5'h10;
    repeat (2) @(posedge aclk);
    `CHK("clamp", 1'b0, boost_en)
    flt <= '0;
    // Open string and overvoltage: latched off, the rest keep running
    chan.no_current <= 6'b00_0010;
    chan.over_volt <= 6'b00_0100;
    repeat (300) @(posedge aclk);
    chan.no_current <= 6'b00_0000;
    chan.over_volt <= 6'b00_0000;
    repeat (300) @(posedge aclk);
    rd(psd_pkg::ADDR_CHAN, 32'h063f_3f00, 34'h0_0004_0200);
    `CHK("feedback", 6'h18, fb)
    rd(psd_pkg::ADDR_STATUS, 32'h0000_0083, 34'h0_0000_0002);
    // Short, heat, all open, sustained overcurrent: latch then clear
    for (i = 0; i < 4; i++) begin
      flt <= fl[i];
      chan.no_current <= (i == 2) ? 6'b01_1110 : 6'b00_0000;
      repeat (800) @(posedge aclk);
      flt <= '0;
      chan.no_current <= 6'b00_0000;
      repeat (20) @(posedge aclk);
      `CHK("latched", 8'h80, so)
      en <= 1'b0;
      repeat (2) @(posedge aclk);
      `CHK("disabled", 8'h00, so)
      en <= 1'b1;
      repeat (40) @(posedge aclk);
      rd(psd_pkg::ADDR_STATUS, 32'h0000_00f3, 34'h0_0000_0002);
    end
    test_done();
  end
endmodule
